//--- src/io_select_regs.svh
// Constants of the I/O chip select decoder: port addresses, config fields, select numbers.
// Assumes a 16-bit host I/O address and 16-bit data bus.
`ifndef IO_SELECT_REGS_SVH
`define IO_SELECT_REGS_SVH
`define PORT_PROG_ADDR      16'h3072
`define PORT_CACHE_FLUSH    16'hf872
`define PORT_SELECT_CONFIG  16'h2872
`define PORT_SERIAL_CONFIG  16'h1872
`define PORT_SYS_CONTROL_A  16'h0092
`define PORT_PMC_OUT0       16'h7072
`define PORT_PMC_OUT1       16'h7872
`define PORT_EMS            16'hf072
`define PORT_EMS_CLK        16'hf472
`define CFG_RTC_LOC         15
`define CFG_PROG_ENABLE     12
`define CFG_HIGH_MASK       11
`define CFG_LOW_MASK_HI     10
`define CFG_LOW_MASK_LO     8
`define CFG_PROG_BUS_LOC    7
`define CFG_FAST_DISK       6
`define CFG_UNUSED          5
`define CFG_SECONDARY       4
`define CFG_FAST_COPRO      3
`define CFG_BLOCK_LOCK      2
`define CFG_DISK_OFF        1
`define CFG_FLOPPY_OFF      0
`define CFG_WRITE_MASK      16'hffdf
`define CFG_RESET           16'h0000
`define PROG_ADDR_RESET     16'h0000
`define LOCK_BIT            3
`define SCSI_ENABLE_BIT     11
`define CS_ROM              5'h00
`define CS_KEYBOARD         5'h01
`define CS_COPRO            5'h02
`define CS_PMC0             5'h03
`define CS_RTC_ALE          5'h05
`define CS_RTC_WR           5'h06
`define CS_RTC_RD           5'h07
`define CS_FLOPPY_OP        5'h08
`define CS_FLOPPY           5'h09
`define CS_FLOPPY_CTL       5'h0a
`define CS_FLOPPY_HD_CTL    5'h0b
`define CS_DISK             5'h0c
`define CS_DISK_IDE         5'h0d
`define CS_SERIAL_A         5'h0e
`define CS_SERIAL_B         5'h10
`define CS_PROG             5'h11
`define CS_SCSI             5'h12
`define CS_FLUSH            5'h13
`define CS_EMS              5'h14
`define CS_EMS_CLK_OFF      5'h15
`define CS_PMC1             5'h17
`define CS_IDLE             5'h1f
`endif

//--- src/io_select_pkg.sv
// Types of the I/O chip select decoder.
// Assumes the constants header is included by users.
package io_select_pkg;
  typedef logic [4:0]  select_number_type;
  typedef logic [15:0] io_word_type;
endpackage : io_select_pkg

//--- src/io_chip_select_decoder.sv
// I/O chip select decoder: encodes host I/O cycles into a five-bit select number.
// Assumes host cycle strobes are synchronous to clock_in, one cycle per I/O access.
// Functional notes
// RQ1: Low mask field ignores zero to four low address bits of programmable match.
// RQ2: Bus location bit puts programmable peripheral on expansion bus when set.
// RQ3: Fast disk mode: first disk data transfer compatible, later ones compressed.
// RQ4: Later fast disk accesses suppress address latch enable and hold disk address.
// RQ5: Config bit 5 has no function; writes to it are ignored.
// RQ6: Primary/secondary bit picks floppy and disk addresses in IDE mode.
// RQ7: Coprocessor cycles use 8-bit timing, or 16-bit when fast bit set.
// RQ8: Lock-inhibit set first blocks password lock; no effect once lock is set.
// RQ9: Disk select off bit stops select numbers 0C and 0D.
// RQ10: Floppy select off bit stops select numbers 08 through 0B.
// RQ11: Any write to cache flush port yields select number 13.
// RQ12: 16-bit read/write register holds programmable match address.
// RQ13: Three-digit fixed ports ignore address bits A15 to A10, except coprocessor 0E0-0FF, which needs A15 to A8 zero.
// RQ14: Selected peripheral is reported as a five-bit encoded number.
// RQ15: Any other decode overrides the programmable select number 11.
// RQ16: Serial B select 10 is suppressed when it overlaps serial A.
// RQ17: Select 00 is the boot ROM select, tied to no I/O address.
// RQ18: Disk select 0C at 1F0-1F7 primary or 170-177 secondary.
// RQ19: Control port 3F7/377 gives 0A with disk off, 0B with disk on.
// RQ20: IDE disk select 0D at 3F6 primary or 3F7 secondary only.
// RQ21: High mask bit makes A15 to A10 part of the programmable compare.
// RQ22: Programmable select 11 is produced only while its enable bit is set.
// RQ23: Each host I/O cycle drives its decoded select number for that cycle.
`timescale 1ns/100ps
`include "io_select_regs.svh"

module io_chip_select_decoder
  import io_select_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // Host I/O cycle
  input  wire logic        io_read_in,
  input  wire logic        io_write_in,
  input  wire logic [15:0] io_address_in,
  input  wire logic [15:0] io_write_data_in,
  input  wire logic        rom_access_in,
  // Strap-level mode inputs and neighbouring serial field
  input  wire logic        ide_mode_in,
  input  wire logic [15:0] serial_config_in,
  // Read data
  output logic      [15:0] io_read_data_out,
  output logic             io_read_valid_out,
  // Select outputs
  output logic      [4:0]  select_number_out,
  output logic             select_valid_out,
  output logic             select_on_expansion_out,
  output logic             sixteen_bit_cycle_out,
  output logic             compressed_timing_out,
  output logic             address_latch_suppress_out,
  // Password lock and status
  output logic             pass_lock_out,
  output logic      [15:0] select_config_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  io_word_type prog_select_match_address_reg;
  io_word_type select_config_and_timing_reg;
  logic        pass_lock_reg;
  logic        disk_streak_reg;
  logic        ide_mode_meta_reg;
  logic        ide_mode_sync_reg;
  logic        wr_cycle;
  logic        rd_cycle;

  assign wr_cycle = io_write_in;
  assign rd_cycle = io_read_in;

  always_ff @(posedge clock_in) begin
    ide_mode_meta_reg <= ide_mode_in;
    ide_mode_sync_reg <= ide_mode_meta_reg;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      prog_select_match_address_reg <= `PROG_ADDR_RESET;
    end else if (wr_cycle && io_address_in == `PORT_PROG_ADDR) begin
      prog_select_match_address_reg <= io_write_data_in; // [RQ12]
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      select_config_and_timing_reg <= `CFG_RESET;
    end else if (wr_cycle && io_address_in == `PORT_SELECT_CONFIG) begin
      select_config_and_timing_reg <= io_write_data_in & `CFG_WRITE_MASK; // [RQ5]
    end
  end

  logic block_pass_lock;
  assign block_pass_lock = select_config_and_timing_reg[`CFG_BLOCK_LOCK];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pass_lock_reg <= 1'b0;
    end else if (wr_cycle && io_address_in == `PORT_SYS_CONTROL_A
                 && io_write_data_in[`LOCK_BIT] && !block_pass_lock) begin
      pass_lock_reg <= 1'b1; // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [2:0] low_mask_sel;
  logic       high_mask_sel;
  logic       prog_select_enable;
  logic       prog_select_bus_loc;
  logic       fast_disk_xfer;
  logic       fast_copro_timing;
  logic       secondary_sel;
  logic       disk_select_off;
  logic       floppy_select_off;
  logic [9:0] low_addr;
  logic [15:0] prog_mask;
  logic       prog_hit;

  assign low_mask_sel        = select_config_and_timing_reg[`CFG_LOW_MASK_HI:`CFG_LOW_MASK_LO];
  assign high_mask_sel       = select_config_and_timing_reg[`CFG_HIGH_MASK];
  assign prog_select_enable  = select_config_and_timing_reg[`CFG_PROG_ENABLE];
  assign prog_select_bus_loc = select_config_and_timing_reg[`CFG_PROG_BUS_LOC];
  assign fast_disk_xfer      = select_config_and_timing_reg[`CFG_FAST_DISK];
  assign fast_copro_timing   = select_config_and_timing_reg[`CFG_FAST_COPRO];
  // The primary/secondary choice only counts in IDE mode; otherwise primary addresses apply.
  assign secondary_sel       = select_config_and_timing_reg[`CFG_SECONDARY]
                               && ide_mode_sync_reg; // [RQ6]
  assign disk_select_off     = select_config_and_timing_reg[`CFG_DISK_OFF];
  assign floppy_select_off   = select_config_and_timing_reg[`CFG_FLOPPY_OFF];
  assign low_addr            = io_address_in[9:0]; // [RQ13]

  always_comb begin
    prog_mask = 16'hffff;
    if (!high_mask_sel) begin
      prog_mask[15:10] = 6'h00; // [RQ21]
    end
    case (low_mask_sel) // [RQ1]
      3'h1:    prog_mask[0:0] = 1'h0;
      3'h2:    prog_mask[1:0] = 2'h0;
      3'h3:    prog_mask[2:0] = 3'h0;
      3'h4:    prog_mask[3:0] = 4'h0;
      default: prog_mask[3:0] = 4'hf;
    endcase
  end

  assign prog_hit = prog_select_enable && // [RQ22]
    ((io_address_in & prog_mask) == (prog_select_match_address_reg & prog_mask));

  function automatic logic serial_hit(input logic [2:0] field, input logic [9:0] a);
    logic [9:0] base;
    base = 10'h000;
    case (field)
      3'h1:    base = 10'h3f8;
      3'h2:    base = 10'h2f8;
      3'h3:    base = 10'h3e8;
      3'h4:    base = 10'h2e8;
      default: base = 10'h000;
    endcase
    serial_hit = (base != 10'h000) && (a[9:3] == base[9:3]);
  endfunction : serial_hit

  logic       disk_data_hit;
  logic       ide_mode;
  logic       fixed_hit;
  logic [4:0] fixed_num;
  assign ide_mode = ide_mode_sync_reg;
  assign disk_data_hit = !disk_select_off && // [RQ9]
    (low_addr[9:3] == (secondary_sel ? 7'h2e : 7'h3e)); // [RQ18]

  always_comb begin
    fixed_hit = 1'b1;
    fixed_num = `CS_IDLE;
    if (io_address_in == `PORT_CACHE_FLUSH && wr_cycle) begin
      fixed_num = `CS_FLUSH; // [RQ11]
    end else if (io_address_in == `PORT_PMC_OUT0 && wr_cycle) begin
      fixed_num = `CS_PMC0;
    end else if (io_address_in == `PORT_PMC_OUT1 && wr_cycle) begin
      fixed_num = `CS_PMC1;
    end else if (io_address_in == `PORT_EMS) begin
      fixed_num = `CS_EMS;
    end else if (io_address_in == `PORT_EMS_CLK) begin
      fixed_num = `CS_EMS_CLK_OFF;
    end else if (serial_config_in[`SCSI_ENABLE_BIT] && io_address_in[15:4] == 12'h353) begin
      fixed_num = `CS_SCSI;
    end else if (io_address_in[15:8] == 8'h00 && io_address_in[7:5] == 3'h7) begin
      fixed_num = `CS_COPRO;
    end else if (low_addr[9:4] == 6'h06 && !low_addr[0]) begin
      fixed_num = `CS_KEYBOARD;
    end else if (low_addr == 10'h070) begin
      fixed_num = `CS_RTC_ALE;
    end else if (low_addr == 10'h071) begin
      fixed_num = wr_cycle ? `CS_RTC_WR : `CS_RTC_RD;
    end else if (disk_data_hit) begin
      fixed_num = `CS_DISK;
    end else if (ide_mode && !disk_select_off &&
                 low_addr == (secondary_sel ? 10'h3f7 : 10'h3f6)) begin
      fixed_num = `CS_DISK_IDE; // [RQ20] [RQ6]
    end else if (!floppy_select_off && low_addr == (secondary_sel ? 10'h372 : 10'h3f2)) begin
      fixed_num = `CS_FLOPPY_OP; // [RQ10]
    end else if (!floppy_select_off && low_addr[9:1] == (secondary_sel ? 9'h1ba : 9'h1fa)) begin
      fixed_num = `CS_FLOPPY;
    end else if (!floppy_select_off && low_addr == (secondary_sel ? 10'h377 : 10'h3f7)) begin
      fixed_num = disk_select_off ? `CS_FLOPPY_CTL : `CS_FLOPPY_HD_CTL; // [RQ19]
    end else if (serial_hit(serial_config_in[7:5], low_addr)) begin
      fixed_num = `CS_SERIAL_A; // [RQ16]
    end else if (serial_hit(serial_config_in[3:1], low_addr)) begin
      fixed_num = `CS_SERIAL_B;
    end else begin
      fixed_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select number output, one cycle per host I/O cycle.

  logic cycle_active;
  logic disk_data_cycle;
  assign cycle_active    = rd_cycle || wr_cycle;
  assign disk_data_cycle = cycle_active && disk_data_hit && low_addr[2:0] == 3'h0;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      select_number_out       <= `CS_IDLE;
      select_valid_out        <= 1'b0;
      select_on_expansion_out <= 1'b0;
      sixteen_bit_cycle_out   <= 1'b0;
    end else begin
      select_valid_out        <= 1'b0;
      select_number_out       <= `CS_IDLE;
      select_on_expansion_out <= 1'b0;
      sixteen_bit_cycle_out   <= 1'b0;
      if (rom_access_in) begin
        select_number_out <= `CS_ROM; // [RQ17]
        select_valid_out  <= 1'b1;
      end else if (cycle_active && fixed_hit) begin
        select_number_out     <= fixed_num; // [RQ14] [RQ23] [RQ15]
        select_valid_out      <= 1'b1;
        sixteen_bit_cycle_out <= (fixed_num == `CS_COPRO) ? fast_copro_timing // [RQ7]
                                 : (fixed_num == `CS_DISK);
      end else if (cycle_active && prog_hit) begin
        select_number_out       <= `CS_PROG;
        select_valid_out        <= 1'b1;
        select_on_expansion_out <= prog_select_bus_loc; // [RQ2]
      end
    end
  end

  // Streak of consecutive disk data cycles with fast transfers on; any other I/O cycle breaks it.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      disk_streak_reg <= 1'b0;
    end else if (cycle_active) begin
      disk_streak_reg <= disk_data_cycle && fast_disk_xfer;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      compressed_timing_out      <= 1'b0;
      address_latch_suppress_out <= 1'b0;
    end else begin
      compressed_timing_out      <= disk_data_cycle && fast_disk_xfer && disk_streak_reg; // [RQ3]
      address_latch_suppress_out <= disk_data_cycle && fast_disk_xfer && disk_streak_reg; // [RQ4]
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      io_read_data_out  <= 16'h0000;
      io_read_valid_out <= 1'b0;
    end else begin
      io_read_valid_out <= 1'b0;
      io_read_data_out  <= 16'h0000;
      if (rd_cycle && io_address_in == `PORT_PROG_ADDR) begin
        io_read_data_out  <= prog_select_match_address_reg;
        io_read_valid_out <= 1'b1;
      end else if (rd_cycle && io_address_in == `PORT_SELECT_CONFIG) begin
        io_read_data_out  <= select_config_and_timing_reg;
        io_read_valid_out <= 1'b1;
      end
    end
  end

  assign pass_lock_out     = pass_lock_reg;
  assign select_config_out = select_config_and_timing_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // One host cycle to the disk data port with fast transfers enabled.
  sequence s_fast_data;
    disk_data_cycle && fast_disk_xfer;
  endsequence

  // Two fast disk data cycles with one idle cycle between them keep the streak going.
  sequence s_disk_pair;
    s_fast_data ##1 !cycle_active ##1 s_fast_data;
  endsequence

  a_flush_select: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ11]
    wr_cycle && !rom_access_in && io_address_in == `PORT_CACHE_FLUSH
    |=> select_number_out == `CS_FLUSH && select_valid_out)
    else $error("cache flush write did not give select 13");

  a_prog_disabled: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ22]
    select_number_out == `CS_PROG && select_valid_out |-> $past(prog_select_enable))
    else $error("programmable select while disabled");

  a_prog_loses: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ15]
    cycle_active && !rom_access_in && fixed_hit && prog_hit |=> select_number_out != `CS_PROG)
    else $error("programmable select not suppressed");

  a_disk_off: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ9]
    select_valid_out && $past(disk_select_off)
    |-> select_number_out != `CS_DISK && select_number_out != `CS_DISK_IDE)
    else $error("disk select while disabled");

  a_floppy_off: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ10]
    select_valid_out && $past(floppy_select_off)
    |-> select_number_out < `CS_FLOPPY_OP || select_number_out > `CS_FLOPPY_HD_CTL)
    else $error("floppy select while disabled");

  a_bit5_ignored: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ5]
    !select_config_and_timing_reg[`CFG_UNUSED])
    else $error("unused config bit stored");

  a_lock_blocked: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ8]
    block_pass_lock && !pass_lock_reg |=> !pass_lock_reg)
    else $error("password lock set while inhibited");

  a_first_compat: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ3]
    disk_data_cycle && fast_disk_xfer && !disk_streak_reg |=> !compressed_timing_out)
    else $error("first fast disk transfer compressed");

  a_later_fast: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ4]
    s_disk_pair |=> address_latch_suppress_out && compressed_timing_out)
    else $error("later fast disk transfer kept address latch");

  a_copro_width: assert property (@(posedge clock_in) disable iff (reset_in) // [RQ7]
    select_valid_out && select_number_out == `CS_COPRO
    |-> sixteen_bit_cycle_out == $past(fast_copro_timing))
    else $error("coprocessor timing width wrong");

endmodule : io_chip_select_decoder

//--- sim/select_strobe_model.sv
// Peripheral-side model: turns the encoded select number into one strobe per peripheral.
// Assumes the select number is qualified by the decoder's one-cycle valid pulse.
`timescale 1ns/100ps
module select_strobe_model
  import io_select_pkg::*;
(
  // Encoded select from the decoder
  input  wire select_number_type select_number_in,
  input  wire logic              select_valid_in,
  // Peripheral strobes, one per select number, active low
  output logic [31:0]            strobe_n_out
);
  always_comb begin
    strobe_n_out = 32'hffffffff;
    if (select_valid_in) begin
      strobe_n_out[select_number_in] = 1'h0;
    end
  end
endmodule : select_strobe_model

//--- sim/test_io_chip_select_decoder.sv
// Self-checking bench for the I/O chip select decoder.
// Assumes the constants header and package are compiled first.
`timescale 1ns/100ps
`include "io_select_regs.svh"
module test_io_chip_select_decoder
  import io_select_pkg::*;
;
  logic              clock_in, reset_in, io_read_in, io_write_in, rom_access_in, ide_mode_in;
  logic [15:0]       io_address_in, io_write_data_in, serial_config_in;
  logic [15:0]       io_read_data_out, select_config_out;
  logic              io_read_valid_out, select_valid_out, select_on_expansion_out;
  logic              sixteen_bit_cycle_out, compressed_timing_out;
  logic              address_latch_suppress_out, pass_lock_out;
  select_number_type select_number_out;
  logic [31:0]       strobe_n, rng;
  logic [15:0]       a, base;
  int                n_fail, check_count, cycle_count;
  logic [15:0]       tbl_a [12] = '{16'h0060, 16'h00e0, 16'h7072, 16'h0070, 16'h0071,
    16'h0071, 16'h03f2, 16'h03f4, 16'h03f7, 16'h01f0, 16'hf872, 16'h7872};
  int                tbl_k [12] = '{0, 0, 1, 1, 1, 0, 1, 0, 0, 0, 1, 1};
  select_number_type tbl_cs [12] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h0b, 5'h0c, 5'h13, 5'h17};

  io_chip_select_decoder uut (.clock_in(clock_in), .reset_in(reset_in),
    .io_read_in(io_read_in), .io_write_in(io_write_in), .io_address_in(io_address_in),
    .io_write_data_in(io_write_data_in), .rom_access_in(rom_access_in),
    .ide_mode_in(ide_mode_in), .serial_config_in(serial_config_in),
    .io_read_data_out(io_read_data_out), .io_read_valid_out(io_read_valid_out),
    .select_number_out(select_number_out), .select_valid_out(select_valid_out),
    .select_on_expansion_out(select_on_expansion_out),
    .sixteen_bit_cycle_out(sixteen_bit_cycle_out),
    .compressed_timing_out(compressed_timing_out),
    .address_latch_suppress_out(address_latch_suppress_out),
    .pass_lock_out(pass_lock_out), .select_config_out(select_config_out));

  select_strobe_model partner (.select_number_in(select_number_out),
    .select_valid_in(select_valid_out), .strobe_n_out(strobe_n));

  always #12.5 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] prog_cfg(input logic hi, input logic [2:0] m,
                                           input logic loc);
    prog_cfg = {3'h0, 1'h1, hi, m, loc, 7'h00};
  endfunction : prog_cfg

  task automatic final_report;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Kind 0 is a read, 1 a write, 2 a boot ROM access; returns once the answer stands.
  task automatic io(input int kind, input logic [15:0] ad, input logic [15:0] d);
    rng = lfsr(rng);
    @(posedge clock_in);
    io_read_in       <= (kind == 0);
    io_write_in      <= (kind == 1);
    rom_access_in    <= (kind == 2);
    io_address_in    <= ad;
    io_write_data_in <= d;
    @(posedge clock_in);
    io_read_in    <= 1'h0;
    io_write_in   <= 1'h0;
    rom_access_in <= 1'h0;
    #1;
  endtask : io

  task automatic sel(input int kind, input logic [15:0] ad, input select_number_type exp);
    io(kind, ad, rng[15:0]);
    check("select number", {11'h0, exp}, {11'h0, select_number_out});
    if (exp != `CS_IDLE) check("strobe", 16'h0, {15'h0, strobe_n[exp]});
  endtask : sel

  task automatic cfg(input logic [15:0] v);
    io(1, `PORT_SELECT_CONFIG, v);
  endtask : cfg

  task automatic done(input string name);
    $display("test %s done, mismatches so far %0d", name, n_fail);
  endtask : done

  always @(posedge clock_in) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 3000) begin
      n_fail++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'h0;
    reset_in = 1'h1;
    {io_read_in, io_write_in, rom_access_in, ide_mode_in} = 4'h0;
    {io_address_in, io_write_data_in, serial_config_in} = 48'h0;
    rng = 32'h6750;
    repeat (5) @(posedge clock_in);
    reset_in <= 1'h0;
    io(0, `PORT_SELECT_CONFIG, 16'h0);
    check("config reset", `CFG_RESET, io_read_data_out);
    check("read valid", 16'h1, {15'h0, io_read_valid_out});
    io(0, `PORT_PROG_ADDR, 16'h0);
    check("match reset", `PROG_ADDR_RESET, io_read_data_out);
    cfg(16'hffff);
    io(0, `PORT_SELECT_CONFIG, 16'h0);
    check("config unused bit", `CFG_WRITE_MASK, io_read_data_out);
    check("config level", `CFG_WRITE_MASK, select_config_out);
    cfg(16'h0000);
    done("registers");
    for (int i = 0; i < 12; i++) begin
      a = tbl_a[i];
      if (a[15:10] == 6'h00 && a != 16'h00e0) a[15:10] = rng[21:16];
      sel(tbl_k[i], a, tbl_cs[i]);
    end
    sel(2, 16'h0000, `CS_ROM);
    io(0, `PORT_CACHE_FLUSH, 16'h0);
    check("flush read valid", 16'h0, {15'h0, io_read_valid_out});
    repeat (3) sel(1, `PORT_CACHE_FLUSH, `CS_FLUSH);
    done("fixed table");
    base = {rng[15:10], 4'h8, rng[5:0]};
    io(1, `PORT_PROG_ADDR, base);
    io(0, `PORT_PROG_ADDR, 16'h0);
    check("match address", base, io_read_data_out);
    for (int m = 0; m < 5; m++) begin
      cfg(prog_cfg(1'h0, m[2:0], 1'h1));
      if (m > 0) begin
        sel(0, base ^ (16'h1 << (m - 1)), `CS_PROG);
        check("on expansion", 16'h1, {15'h0, select_on_expansion_out});
      end
      sel(0, base ^ (16'h1 << m), `CS_IDLE);
    end
    sel(0, base ^ 16'h8000, `CS_PROG);
    cfg(prog_cfg(1'h1, 3'h0, 1'h0));
    sel(0, base ^ 16'h8000, `CS_IDLE);
    sel(1, base, `CS_PROG);
    check("on local bus", 16'h0, {15'h0, select_on_expansion_out});
    cfg(16'h0000);
    sel(0, base, `CS_IDLE);
    check("unmapped read valid", 16'h0, {15'h0, io_read_valid_out});
    io(1, `PORT_PROG_ADDR, 16'h01f0);
    cfg(prog_cfg(1'h1, 3'h0, 1'h0));
    sel(0, 16'h01f0, `CS_DISK);
    done("programmable select");
    cfg(16'h0001);
    sel(1, 16'h03f2, `CS_IDLE);
    sel(0, 16'h03f7, `CS_IDLE);
    cfg(16'h0002);
    sel(0, 16'h01f0, `CS_IDLE);
    sel(0, 16'h03f7, `CS_FLOPPY_CTL);
    ide_mode_in <= 1'h1;
    cfg(16'h0010);
    sel(0, 16'h0170, `CS_DISK);
    sel(0, 16'h01f0, `CS_IDLE);
    sel(1, 16'h0372, `CS_FLOPPY_OP);
    sel(0, 16'h0375, `CS_FLOPPY);
    sel(0, 16'h0377, `CS_FLOPPY_HD_CTL);
    sel(0, 16'h03f7, `CS_DISK_IDE);
    cfg(16'h0000);
    sel(0, 16'h03f6, `CS_DISK_IDE);
    sel(1, 16'h03f2, `CS_FLOPPY_OP);
    cfg(16'h0002);
    sel(0, 16'h03f6, `CS_IDLE);
    ide_mode_in <= 1'h0;
    cfg(16'h0010);
    sel(0, 16'h01f0, `CS_DISK);
    done("disk and floppy");
    cfg(16'h0008);
    sel(0, 16'h00e0, `CS_COPRO);
    check("copro 16-bit", 16'h1, {15'h0, sixteen_bit_cycle_out});
    cfg(16'h0000);
    sel(1, 16'h00e0, `CS_COPRO);
    check("copro 8-bit", 16'h0, {15'h0, sixteen_bit_cycle_out});
    cfg(16'h0040);
    sel(0, 16'h01f0, `CS_DISK);
    check("first compressed", 16'h0, {15'h0, compressed_timing_out});
    sel(0, 16'h01f0, `CS_DISK);
    check("later compressed", 16'h1, {15'h0, compressed_timing_out});
    check("latch suppress", 16'h1, {15'h0, address_latch_suppress_out});
    cfg(16'h0000);
    repeat (2) sel(0, 16'h01f0, `CS_DISK);
    check("slow compressed", 16'h0, {15'h0, compressed_timing_out});
    done("timing");
    cfg(16'h0004);
    io(1, `PORT_SYS_CONTROL_A, 16'h0008);
    check("lock blocked", 16'h0, {15'h0, pass_lock_out});
    cfg(16'h0000);
    io(1, `PORT_SYS_CONTROL_A, 16'h0008);
    check("lock set", 16'h1, {15'h0, pass_lock_out});
    cfg(16'h0004);
    check("lock kept", 16'h1, {15'h0, pass_lock_out});
    serial_config_in <= 16'h0022;
    sel(0, 16'h03f8, `CS_SERIAL_A);
    serial_config_in <= 16'h0004;
    sel(1, 16'h02f8, `CS_SERIAL_B);
    serial_config_in <= 16'h0800;
    sel(0, 16'h3534, `CS_SCSI);
    sel(0, 16'hf072, `CS_EMS);
    sel(1, 16'hf472, `CS_EMS_CLK_OFF);
    done("lock and serial");
    final_report;
  end
endmodule : test_io_chip_select_decoder
